// [bench/ext_mem_model.sv]
`timescale 1ns/1ps
module ext_mem_model #(
   parameter int AW = 10
) (
   input  wire logic          clk_i,
   input  wire logic [AW-1:0] addr_i,
   input  wire logic          rd_i,
   input  wire logic          wr_i,
   input  wire logic [7:0]    wdata_i,
   output logic      [7:0]    rdata_o
);
   logic [7:0] mem [2**AW];

   initial rdata_o = 8'h5a;

   // Flat array, no bank select in front of it
   always @(posedge clk_i) begin
      if (wr_i) begin
         mem[addr_i] <= wdata_i;
      end
      // Data holds one cycle only, then toggles so stale reads show up
      if (rd_i) begin
         rdata_o <= mem[addr_i];
      end else begin
         rdata_o <= ~rdata_o;
      end
   end
endmodule

// [bench/tb_extended_byte_alu_ops.sv]
`timescale 1ns/1ps
module tb_extended_byte_alu_ops;
   logic        clk, rst, cyc, stb, we, ack, mrd, mwr;
   logic [3:0]  adr, sel;
   logic [31:0] wdat, rdat, seed;
   logic [9:0]  maddr;
   logic [7:0]  mwd, mrdat;
   int          bad_count, n_checks;

   ext_byte_alu #(.AW(10)) dut (
      .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
      .mem_addr_o(maddr), .mem_rd_o(mrd), .mem_wr_o(mwr),
      .mem_wdata_o(mwd), .mem_rdata_i(mrdat));

   ext_mem_model #(.AW(10)) mm (
      .clk_i(clk), .addr_i(maddr), .rd_i(mrd), .wr_i(mwr),
      .wdata_i(mwd), .rdata_o(mrdat));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Returns {acc, mem, flags} as the operation should leave them
   function automatic logic [21:0] model(input logic [4:0] op,
      input logic [7:0] a, m, input logic [5:0] f, input logic [2:0] bi);
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] ra, rm, o, adj;
      logic [5:0] nf;
      logic       c;
      ra = a;
      rm = m;
      nf = f;
      o = m;
      c = 1'b0;
      case (op)
         0, 1: c = f[0];
         27, 28: begin
            o = ~m;
            c = f[0];
         end
         4: ra = a & m;
         5: rm = a & m;
         6: ra = a | m;
         7: rm = a | m;
         8: rm = ext_alu_pkg::CLR_BYTE;
         9: rm[bi] = 1'b0;
         10: rm = ~m;
         11: ra = ~m;
         12: begin
            adj[3:0] = (a[3:0] > ext_alu_pkg::BCD_MAX || f[1]) ?
                       ext_alu_pkg::BCD_ADJ : 4'h0;
            adj[7:4] = (a[7:4] > ext_alu_pkg::BCD_MAX || f[0]) ?
                       ext_alu_pkg::BCD_ADJ : 4'h0;
            s = {1'b0, a} + {1'b0, adj};
            rm = s[7:0];
            nf[0] = f[0] | s[8];
         end
         13: rm = m - 8'h01;
         14: ra = m - 8'h01;
         15: rm = m + 8'h01;
         16: ra = m + 8'h01;
         17: ra = m;
         18: rm = a;
         19: rm = {m[6:0], m[7]};
         20: ra = {m[6:0], m[7]};
         21: rm = {m[6:0], f[0]};
         22: ra = {m[6:0], f[0]};
         23: rm = {m[0], m[7:1]};
         24: ra = {m[0], m[7:1]};
         25: rm = {f[0], m[7:1]};
         26: ra = {f[0], m[7:1]};
         default: ;
      endcase
      if (op inside {21, 22}) nf[0] = m[7];
      if (op inside {25, 26}) nf[0] = m[0];
      if (op < 4 || op inside {27, 28}) begin
         s = {1'b0, a} + {1'b0, o} + {8'h00, c};
         h = {1'b0, a[3:0]} + {1'b0, o[3:0]} + {4'h0, c};
         nf[0] = s[8];
         nf[1] = h[4];
         nf[2] = (s[7:0] == 8'h00);
         nf[3] = (a[7] == o[7]) && (s[7] != a[7]);
         nf[4] = nf[3] ^ s[7];
         if (op > 26) nf[5] = nf[2] & f[5];
         if (op inside {0, 2, 27}) ra = s[7:0];
         else rm = s[7:0];
      end
      if (op inside {4, 6, 11, 14, 16}) nf[2] = (ra == 8'h00);
      if (op inside {5, 7, 10, 15}) nf[2] = (rm == 8'h00);
      return {ra, rm, nf};
   endfunction

   task automatic chk_byte(input string nm, input logic [7:0] e, g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_flags(input string nm, input logic [5:0] e, g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic wb(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 40);
      q = rdat;
      if (ack !== 1'b1) begin
         bad_count++;
         $display("MISMATCH wb_ack expected 1 seen %b", ack);
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask

   task automatic run_op(input logic [4:0] op, input logic [7:0] a, m,
      input logic [5:0] f, input logic [2:0] bi, input logic [9:0] ad);
      logic [31:0] q;
      logic [21:0] e;
      int          n;
      e = model(op, a, m, f, bi);
      mm.mem[ad] = m;
      wb(1'b1, ext_alu_pkg::ACC_OFS, {24'h0, a}, q);
      wb(1'b1, ext_alu_pkg::FLAG_OFS, {26'h0, f}, q);
      wb(1'b1, ext_alu_pkg::ADDR_OFS, {22'h0, ad}, q);
      wb(1'b1, ext_alu_pkg::CMD_OFS, {21'h0, bi, 3'h0, op}, q);
      n = 0;
      do begin
         wb(1'b0, ext_alu_pkg::CMD_OFS, 32'h0, q);
         n++;
      end while (q[31] !== 1'b0 && n < 20);
      wb(1'b0, ext_alu_pkg::ACC_OFS, 32'h0, q);
      chk_byte("acc", e[21:14], q[7:0]);
      wb(1'b0, ext_alu_pkg::FLAG_OFS, 32'h0, q);
      chk_flags("flags", e[5:0], q[5:0]);
      chk_byte("mem", e[13:6], mm.mem[ad]);
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      finish_test();
   end

   initial begin
      logic [31:0] q;
      {cyc, stb, we, adr, wdat} = '0;
      sel = 4'hf;
      rst = 1'b1;
      bad_count = 0;
      n_checks = 0;
      seed = 32'h8182;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      wb(1'b0, ext_alu_pkg::ACC_OFS, 32'h0, q);
      chk_byte("acc_reset", ext_alu_pkg::ACC_RST, q[7:0]);
      wb(1'b0, ext_alu_pkg::FLAG_OFS, 32'h0, q);
      chk_flags("flags_reset", ext_alu_pkg::FLAG_RST, q[5:0]);
      wb(1'b1, 4'h2, 32'hffffffff, q);
      wb(1'b0, 4'h2, 32'h0, q);
      chk_byte("unmapped", 8'h00, q[7:0]);
      $display("test reset done");
      run_op(5'd27, 8'h50, 8'h50, 6'h21, 3'h0, 10'h3ff);
      run_op(5'd28, 8'h10, 8'h20, 6'h01, 3'h0, 10'h000);
      run_op(5'd28, 8'h33, 8'h32, 6'h20, 3'h0, 10'h155);
      run_op(5'd12, 8'h9a, 8'h00, 6'h00, 3'h0, 10'h2aa);
      run_op(5'd12, 8'h23, 8'h77, 6'h3e, 3'h0, 10'h101);
      run_op(5'd0, 8'h7f, 8'h00, 6'h01, 3'h0, 10'h0f0);
      run_op(5'd3, 8'hff, 8'h01, 6'h3f, 3'h0, 10'h00f);
      run_op(5'd9, 8'h00, 8'hff, 6'h15, 3'h7, 10'h200);
      run_op(5'd21, 8'h00, 8'h80, 6'h00, 3'h0, 10'h300);
      run_op(5'd26, 8'h00, 8'h01, 6'h00, 3'h0, 10'h301);
      $display("test directed done");
      // Reset again mid-run, then try a write without its byte enable
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      wb(1'b0, ext_alu_pkg::FLAG_OFS, 32'h0, q);
      chk_flags("flags_rerun", ext_alu_pkg::FLAG_RST, q[5:0]);
      sel <= 4'h0;
      wb(1'b1, ext_alu_pkg::ACC_OFS, 32'h000000a5, q);
      sel <= 4'hf;
      wb(1'b0, ext_alu_pkg::ACC_OFS, 32'h0, q);
      chk_byte("acc_no_sel", ext_alu_pkg::ACC_RST, q[7:0]);
      $display("test rerun done");
      for (int op = 0; op < 32; op++) begin
         for (int k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            run_op(5'(op), seed[7:0], seed[15:8], seed[21:16],
                   seed[24:22], seed[31:22]);
         end
      end
      $display("test random done");
      finish_test();
   end
endmodule

// [verilog/ext_alu_pkg.sv]
package ext_alu_pkg;

   // Wishbone byte offsets
   localparam logic [3:0] ACC_OFS  = 4'h0;
   localparam logic [3:0] FLAG_OFS = 4'h4;
   localparam logic [3:0] ADDR_OFS = 4'h8;
   localparam logic [3:0] CMD_OFS  = 4'hc;

   // Command word fields
   localparam int OP_LSB   = 0;
   localparam int OP_W     = 5;
   localparam int BIT_LSB  = 8;
   localparam int BUSY_BIT = 31;

   localparam logic [7:0] ACC_RST  = 8'h00;
   localparam logic [7:0] CLR_BYTE = 8'h00;
   localparam logic [3:0] BCD_MAX  = 4'h9;
   localparam logic [3:0] BCD_ADJ  = 4'h6;

   typedef struct packed {
      logic carry_zero_bit;
      logic sign_compare_bit;
      logic signed_wrap_bit;
      logic result_null_bit;
      logic nibble_carry_bit;
      logic ripple_out_bit;
   } flags_t;

   localparam flags_t FLAG_RST = '0;

   typedef enum logic [OP_W-1:0] {
      add_mem_carry_to_acc, add_carry_into_mem, add_mem_to_acc,
      add_into_mem, and_mem_to_acc, and_into_mem, or_mem_to_acc,
      or_into_mem, clear_mem_byte, clear_mem_bit, invert_mem,
      invert_to_acc, decimal_adjust_to_mem, decrement_mem,
      decrement_to_acc, increment_mem, increment_to_acc,
      move_mem_to_acc, move_acc_to_mem, rotate_left_mem,
      rotate_left_to_acc, rotate_left_thru_flag,
      rotate_left_thru_flag_acc, rotate_right_mem, rotate_right_to_acc,
      rotate_right_thru_flag, rotate_right_thru_flag_acc,
      sub_borrow_to_acc, sub_borrow_into_mem, no_op_29, no_op_30,
      no_op_31
   } op_t;

endpackage

// [verilog/ext_byte_alu.sv]
`timescale 1ns/1ps
// Function
// - Memory address is flat, no bank selection
// - Add with carry, five arithmetic flags
// - Plain add, same five flags
// - AND result, only zero flag
// - OR result, only zero flag
// - Clear byte or bit, no flags
// - Complement, zero flag, acc form keeps memory
// - Decimal adjust adds six per nibble
// - Decimal adjust changes only carry flag
// - Decrement; acc form updates zero flag
// - Increment updates zero flag both forms
// - Move either way, flags untouched
// - Rotate left, bit 7 into bit 0
// - Rotate left through carry flag
// - Rotate right, bit 0 into bit 7
// - Rotate right through carry flag
// - Subtract with borrow, six flags
// - Carry cleared on negative, else set
// - Memory form of subtract flags identical
module ext_byte_alu #(
   parameter int AW = 10
) (
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          cyc_i,
   input  wire logic          stb_i,
   input  wire logic          we_i,
   input  wire logic [3:0]    adr_i,
   input  wire logic [3:0]    sel_i,
   input  wire logic [31:0]   dat_i,
   output logic      [31:0]   dat_o,
   output logic               ack_o,
   output logic      [AW-1:0] mem_addr_o,
   output logic               mem_rd_o,
   output logic               mem_wr_o,
   output logic      [7:0]    mem_wdata_o,
   input  wire logic [7:0]    mem_rdata_i
);

   typedef enum {ST_IDLE, ST_READ, ST_EXEC, ST_WRITE} state_t;

   state_t                state;
   ext_alu_pkg::op_t      op;
   ext_alu_pkg::flags_t   flags;
   ext_alu_pkg::flags_t   next_flags;
   logic [7:0]            acc;
   logic [7:0]            next_acc;
   logic [7:0]            next_res;
   logic                  next_to_mem;
   logic [AW-1:0]         addr;
   logic [2:0]            bit_idx;
   logic                  wb_req;
   logic                  wb_wr;
   logic                  busy;
   logic                  exec;
   logic [7:0]            m;
   logic [7:0]            opnd;
   logic                  sub_op;
   logic                  cin;
   logic [8:0]            sum;
   logic [4:0]            nib;
   logic [7:0]            logic_res;
   logic                  lo_adj;
   logic                  hi_adj;
   logic [8:0]            bcd;
   logic [7:0]            z_res;

   assign wb_req = cyc_i && stb_i && !ack_o;
   // Register writes take effect on the edge where the master samples ack high
   assign wb_wr  = cyc_i && stb_i && we_i && ack_o;
   assign busy   = (state != ST_IDLE);
   assign exec   = (state == ST_EXEC);
   assign m      = mem_rdata_i;

   // Single-cycle registered acknowledge, dropped in the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= wb_req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (wb_req && !we_i) begin
         if (adr_i == ext_alu_pkg::ACC_OFS) begin
            dat_o <= {24'h000000, acc};
         end else if (adr_i == ext_alu_pkg::FLAG_OFS) begin
            dat_o <= {26'h0000000, flags};
         end else if (adr_i == ext_alu_pkg::ADDR_OFS) begin
            dat_o <= 32'(addr);
         end else if (adr_i == ext_alu_pkg::CMD_OFS) begin
            dat_o <= {busy, 20'h00000, bit_idx, 3'h0, op};
         end else begin
            dat_o <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addr <= '0;
      end else if (wb_wr && !busy && (sel_i[1:0] != 2'b00)
                   && adr_i == ext_alu_pkg::ADDR_OFS) begin
         addr <= dat_i[AW-1:0];
      end
   end

   // Commands written while busy are dropped so one op runs at a time
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         op      <= ext_alu_pkg::no_op_31;
         bit_idx <= 3'h0;
      end else if (wb_wr && !busy && sel_i[0]
                   && adr_i == ext_alu_pkg::CMD_OFS) begin
         op      <= ext_alu_pkg::op_t'(dat_i[ext_alu_pkg::OP_LSB +: 5]);
         bit_idx <= dat_i[ext_alu_pkg::BIT_LSB +: 3];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (wb_wr && sel_i[0]
                   && adr_i == ext_alu_pkg::CMD_OFS) begin
                  state <= ST_READ;
               end
            end
            ST_READ:  state <= ST_EXEC;
            ST_EXEC:  state <= next_to_mem ? ST_WRITE : ST_IDLE;
            default:  state <= ST_IDLE;
         endcase
      end
   end

   // Full address always, so every data section is reachable
   assign mem_addr_o = addr;
   assign mem_rd_o   = (state == ST_READ);
   assign mem_wr_o   = (state == ST_WRITE);

   // One adder serves add and subtract; subtract adds ~m plus carry
   always_comb begin
      sub_op = (op == ext_alu_pkg::sub_borrow_to_acc)
            || (op == ext_alu_pkg::sub_borrow_into_mem);
      opnd   = sub_op ? ~m : m;
      cin    = 1'b0;
      if (sub_op || op == ext_alu_pkg::add_mem_carry_to_acc
          || op == ext_alu_pkg::add_carry_into_mem) begin
         cin = flags.ripple_out_bit;
      end
      sum = 9'(acc) + 9'(opnd) + 9'(cin);
      nib = 5'(acc[3:0]) + 5'(opnd[3:0]) + 5'(cin);
      lo_adj = (acc[3:0] > ext_alu_pkg::BCD_MAX)
            || flags.nibble_carry_bit;
      hi_adj = (acc[7:4] > ext_alu_pkg::BCD_MAX)
            || flags.ripple_out_bit;
      bcd = 9'(acc) + 9'({hi_adj ? ext_alu_pkg::BCD_ADJ : 4'h0,
                          lo_adj ? ext_alu_pkg::BCD_ADJ : 4'h0});
   end

   always_comb begin
      next_res    = acc;
      next_acc    = acc;
      next_flags  = flags;
      next_to_mem = 1'b0;
      logic_res   = 8'h00;
      z_res       = 8'h00;
      case (op)
         ext_alu_pkg::add_mem_carry_to_acc,
         ext_alu_pkg::add_carry_into_mem,
         ext_alu_pkg::add_mem_to_acc,
         ext_alu_pkg::add_into_mem,
         ext_alu_pkg::sub_borrow_to_acc,
         ext_alu_pkg::sub_borrow_into_mem: begin
            next_res = sum[7:0];
            next_to_mem = (op == ext_alu_pkg::add_carry_into_mem)
                       || (op == ext_alu_pkg::add_into_mem)
                       || (op == ext_alu_pkg::sub_borrow_into_mem);
            // Carry out of a+~m+c is set exactly when no borrow
            next_flags.ripple_out_bit   = sum[8];
            next_flags.nibble_carry_bit = nib[4];
            next_flags.result_null_bit  = (sum[7:0] == 8'h00);
            next_flags.signed_wrap_bit  = (acc[7] == opnd[7])
                                       && (sum[7] != acc[7]);
            next_flags.sign_compare_bit = next_flags.signed_wrap_bit
                                       ^ sum[7];
            if (sub_op) begin
               // Zero over a chain of bytes
               next_flags.carry_zero_bit = (sum[7:0] == 8'h00)
                                        && flags.carry_zero_bit;
            end
         end
         ext_alu_pkg::and_mem_to_acc, ext_alu_pkg::and_into_mem,
         ext_alu_pkg::or_mem_to_acc, ext_alu_pkg::or_into_mem: begin
            if (op == ext_alu_pkg::and_mem_to_acc
                || op == ext_alu_pkg::and_into_mem) begin
               logic_res = acc & m;
            end else begin
               logic_res = acc | m;
            end
            next_res = logic_res;
            next_to_mem = (op == ext_alu_pkg::and_into_mem)
                       || (op == ext_alu_pkg::or_into_mem);
            next_flags.result_null_bit = (logic_res == 8'h00);
         end
         ext_alu_pkg::clear_mem_byte: begin
            next_res    = ext_alu_pkg::CLR_BYTE;
            next_to_mem = 1'b1;
         end
         ext_alu_pkg::clear_mem_bit: begin
            next_res          = m;
            next_res[bit_idx] = 1'b0;
            next_to_mem       = 1'b1;
         end
         ext_alu_pkg::invert_mem, ext_alu_pkg::invert_to_acc: begin
            next_res = ~m;
            next_to_mem = (op == ext_alu_pkg::invert_mem);
            next_flags.result_null_bit = (m == 8'hff);
         end
         ext_alu_pkg::decimal_adjust_to_mem: begin
            next_res    = bcd[7:0];
            next_to_mem = 1'b1;
            // Sticky so a multi-byte decimal sum keeps its carry
            next_flags.ripple_out_bit = flags.ripple_out_bit
                                     | bcd[8];
         end
         ext_alu_pkg::decrement_mem, ext_alu_pkg::decrement_to_acc: begin
            z_res = m - 8'h01;
            next_res = z_res;
            next_to_mem = (op == ext_alu_pkg::decrement_mem);
            if (op == ext_alu_pkg::decrement_to_acc) begin
               next_flags.result_null_bit = (z_res == 8'h00);
            end
         end
         ext_alu_pkg::increment_mem, ext_alu_pkg::increment_to_acc: begin
            z_res = m + 8'h01;
            next_res = z_res;
            next_to_mem = (op == ext_alu_pkg::increment_mem);
            next_flags.result_null_bit = (z_res == 8'h00);
         end
         ext_alu_pkg::move_mem_to_acc: begin
            next_res = m;
         end
         ext_alu_pkg::move_acc_to_mem: begin
            next_res    = acc;
            next_to_mem = 1'b1;
         end
         ext_alu_pkg::rotate_left_mem, ext_alu_pkg::rotate_left_to_acc: begin
            next_res = {m[6:0], m[7]};
            next_to_mem = (op == ext_alu_pkg::rotate_left_mem);
         end
         ext_alu_pkg::rotate_left_thru_flag,
         ext_alu_pkg::rotate_left_thru_flag_acc: begin
            next_res = {m[6:0], flags.ripple_out_bit};
            next_to_mem = (op == ext_alu_pkg::rotate_left_thru_flag);
            next_flags.ripple_out_bit = m[7];
         end
         ext_alu_pkg::rotate_right_mem, ext_alu_pkg::rotate_right_to_acc: begin
            next_res = {m[0], m[7:1]};
            next_to_mem = (op == ext_alu_pkg::rotate_right_mem);
         end
         ext_alu_pkg::rotate_right_thru_flag,
         ext_alu_pkg::rotate_right_thru_flag_acc: begin
            next_res = {flags.ripple_out_bit, m[7:1]};
            next_to_mem = (op == ext_alu_pkg::rotate_right_thru_flag);
            next_flags.ripple_out_bit = m[0];
         end
         default: begin
            next_res = acc;
         end
      endcase
      if (!next_to_mem && op <= ext_alu_pkg::sub_borrow_into_mem) begin
         next_acc = next_res;
      end
   end

   // Software writes to acc and flags are ignored while an op runs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc <= ext_alu_pkg::ACC_RST;
      end else if (exec) begin
         acc <= next_acc;
      end else if (wb_wr && !busy && sel_i[0]
                   && adr_i == ext_alu_pkg::ACC_OFS) begin
         acc <= dat_i[7:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags <= ext_alu_pkg::FLAG_RST;
      end else if (exec) begin
         flags <= next_flags;
      end else if (wb_wr && !busy && sel_i[0]
                   && adr_i == ext_alu_pkg::FLAG_OFS) begin
         flags <= ext_alu_pkg::flags_t'(dat_i[5:0]);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mem_wdata_o <= 8'h00;
      end else if (exec) begin
         mem_wdata_o <= next_res;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_add_acc_sum: assert property (
      exec && op == ext_alu_pkg::add_mem_to_acc
      |=> acc == 8'($past(acc) + $past(mem_rdata_i)))
      else $error("add result wrong");
   chk_and_flags_only: assert property (
      exec && op == ext_alu_pkg::and_mem_to_acc
      |=> flags.ripple_out_bit == $past(flags.ripple_out_bit)
          && flags.result_null_bit == (acc == 8'h00))
      else $error("and flags wrong");
   chk_clear_byte_zero: assert property (
      exec && op == ext_alu_pkg::clear_mem_byte
      |=> mem_wr_o && mem_wdata_o == 8'h00 && $stable(flags))
      else $error("clear byte wrong");
   chk_invert_acc_mem: assert property (
      exec && op == ext_alu_pkg::invert_to_acc
      |=> !mem_wr_o && acc == ~$past(mem_rdata_i))
      else $error("invert to acc wrong");
   chk_daa_other_flags: assert property (
      exec && op == ext_alu_pkg::decimal_adjust_to_mem
      |=> mem_wr_o && flags[5:1] == $past(flags[5:1]) ##1 !mem_wr_o)
      else $error("decimal adjust flags wrong");
   chk_inc_zero_flag: assert property (
      exec && op == ext_alu_pkg::increment_mem
      |=> flags.result_null_bit == ($past(mem_rdata_i) == 8'hff))
      else $error("increment zero flag wrong");
   chk_move_no_flags: assert property (
      exec && (op == ext_alu_pkg::move_mem_to_acc
               || op == ext_alu_pkg::move_acc_to_mem)
      |=> $stable(flags))
      else $error("move changed flags");
   chk_rotate_left_wrap: assert property (
      exec && op == ext_alu_pkg::rotate_left_mem
      |=> mem_wr_o && mem_wdata_o == {$past(mem_rdata_i[6:0]),
                                      $past(mem_rdata_i[7])})
      else $error("rotate left wrong");
   chk_sub_carry_sign: assert property (
      exec && sub_op
      |=> flags.ripple_out_bit == ({1'b0, $past(acc)} >=
          9'($past(mem_rdata_i)) + 9'(!$past(flags.ripple_out_bit))))
      else $error("subtract carry wrong");
   chk_read_then_exec: assert property (
      state == ST_READ |-> mem_rd_o && !mem_wr_o
      ##1 exec && $stable(mem_addr_o))
      else $error("read sequence wrong");

   cov_add_carry: cover property (exec
                                  && op == ext_alu_pkg::add_carry_into_mem);
   cov_sub_borrow: cover property (exec && sub_op && !flags.ripple_out_bit);
   cov_daa_carry: cover property (exec
                                  && op == ext_alu_pkg::decimal_adjust_to_mem
                                  && bcd[8]);
   cov_rotate_thru: cover property (exec
                                    && op == ext_alu_pkg::rotate_right_thru_flag);

endmodule
